// *** dv/can_init_mode_and_rx_search_tb.sv ***
/*
  self-checking bench for the can mode controller: apb register tasks, mode
  walk, receive placement and transmit choice.
  assumes can_node_model drives the engine side inputs.
*/
`timescale 1ns/1ps
`include "can_ctrl_regs.svh"
module can_init_mode_and_rx_search_tb;
  localparam logic [31:0] EXT  = 32'h8000_0000;
  localparam logic [28:0] ID_A = 29'h1234567;
  localparam logic [28:0] ID_B = 29'h0abcdef;
  localparam logic [28:0] ID_C = 29'h0111111;
  localparam logic [28:0] ID_D = 29'h0222222;
  localparam logic [28:0] ID_E = 29'h0333333;
  logic        ref_clk     = 1'b0;
  logic        nrst        = 1'b0;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [11:0] paddr       = 12'h000;
  logic [31:0] pwdata      = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        bus_busy;
  logic        rx_frame_done;
  logic [28:0] rx_id;
  logic        rx_ide;
  logic        err_event;
  logic [2:0]  op_mode;
  logic        ctrl_enabled;
  logic [3:0]  clock_divider;
  logic        tx_valid;
  logic [3:0]  tx_buf;
  logic [31:0] q;
  logic        e;
  int          n_mismatch  = 0;
  int          check_count = 0;

  always #12.5 ref_clk = ~ref_clk;

  can_node_model node (
    .ref_clk       (ref_clk),
    .bus_busy      (bus_busy),
    .rx_frame_done (rx_frame_done),
    .rx_id         (rx_id),
    .rx_ide        (rx_ide),
    .err_event     (err_event)
  );

  can_mode_ctrl #(.NB(16)) DUT (
    .ref_clk       (ref_clk),
    .nrst          (nrst),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .bus_busy      (bus_busy),
    .rx_frame_done (rx_frame_done),
    .rx_id         (rx_id),
    .rx_ide        (rx_ide),
    .err_event     (err_event),
    .op_mode       (op_mode),
    .ctrl_enabled  (ctrl_enabled),
    .clock_divider (clock_divider),
    .tx_valid      (tx_valid),
    .tx_buf        (tx_buf)
  );

  function automatic logic [11:0] ba(input int m, input int w);
    return 12'h100 + 12'(m * 16 + w * 4);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // request held until pready is sampled high; data taken at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q, exp);
  endtask

  // software waits for the mode field to read the requested value
  task automatic set_mode(input logic [2:0] m);
    int n;
    n = 0;
    wr(`OFS_MODULE_CTRL, {29'h0, m});
    do begin
      apb(1'b0, `OFS_MODULE_CTRL, 32'h0);
      n++;
    end while (q[2:0] !== m && n < 20);
    check(32'(q[2:0]), 32'(m));
  endtask

  // ready is set last: conf and id writes are refused once it is up
  task automatic setbuf(input int m, input logic [2:0] t, input logic ovr_en,
                        input logic u, input logic [31:0] idw);
    wr(ba(m, 1), {26'h0, t, 1'b0, ovr_en, u});
    wr(ba(m, 2), idw);
    wr(ba(m, 0), 32'h100);
  endtask

  initial begin
    #250000;
    n_mismatch++;
    close_out();
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    check(32'(ctrl_enabled), 32'h0);
    wr(`OFS_CLOCK_SEL, 32'h5);
    wr(`OFS_GLOBAL_CTRL, 32'h1);
    rd_chk(`OFS_MODULE_CTRL, 32'h0);
    check(32'(ctrl_enabled), 32'h1);
    wr(`OFS_CLOCK_SEL, 32'ha);
    rd_chk(`OFS_CLOCK_SEL, 32'h5);
    check(32'(clock_divider), 32'h5);
    apb(1'b0, 12'h0f0, 32'h0);
    check(32'(e), 32'h1);
    for (int m = 0; m < 16; m++) begin
      wr(ba(m, 0), 32'h7);
      wr(ba(m, 1), 32'h0);
      rd_chk(ba(m, 0), 32'h0);
    end
    setbuf(5, 3'h1, 1'b0, 1'b1, EXT | ID_A);
    setbuf(1, 3'h2, 1'b0, 1'b1, EXT | ID_A);
    setbuf(3, 3'h2, 1'b0, 1'b1, EXT | ID_A);
    setbuf(2, 3'h3, 1'b0, 1'b1, EXT | ID_B);
    setbuf(4, 3'h3, 1'b0, 1'b1, EXT | ID_B);
    setbuf(6, 3'h4, 1'b0, 1'b1, EXT | ID_B);
    setbuf(7, 3'h1, 1'b0, 1'b0, EXT | ID_C);
    setbuf(8, 3'h6, 1'b0, 1'b1, EXT | ID_D);
    setbuf(9, 3'h1, 1'b0, 1'b1, EXT | ID_D);
    wr(ba(9, 0), 32'h1);
    setbuf(10, 3'h5, 1'b1, 1'b1, EXT | ID_E);
    setbuf(11, 3'h0, 1'b0, 1'b1, EXT | 32'h300);
    setbuf(12, 3'h0, 1'b0, 1'b1, EXT | 32'h080);
    setbuf(13, 3'h0, 1'b0, 1'b1, EXT | 32'h4000_0080);
    for (int m = 11; m < 14; m++) wr(ba(m, 0), 32'h200);
    wr(ba(5, 1), 32'h0);
    rd_chk(ba(5, 1), 32'h9);
    wr(ba(5, 2), 32'h0);
    rd_chk(ba(5, 2), EXT | ID_A);
    set_mode(3'h1);
    check(32'(op_mode), 32'h1);
    check(32'(tx_valid), 32'h1);
    check(32'(tx_buf), 32'hc);
    node.frame(ID_A, 1'b1);
    rd_chk(`OFS_RX_RESULT, 32'h15);
    rd_chk(ba(5, 0), 32'h5);
    node.frame(ID_A, 1'b1);
    rd_chk(`OFS_FRAME_STAT, 32'h3);
    for (int m = 1; m < 4; m += 2) rd_chk(ba(m, 0), 32'h1);
    node.frame(ID_B, 1'b1);
    rd_chk(`OFS_RX_RESULT, 32'h12);
    node.frame(ID_C, 1'b1);
    rd_chk(`OFS_FRAME_STAT, 32'h0);
    node.frame(ID_D, 1'b1);
    rd_chk(`OFS_FRAME_STAT, 32'h0);
    repeat (2) begin
      node.frame(ID_E, 1'b1);
      rd_chk(`OFS_RX_RESULT, 32'h1a);
    end
    rd_chk(`OFS_FRAME_STAT, 32'h2);
    node.errs(3);
    node.hold(1'b1);
    wr(`OFS_MODULE_CTRL, 32'h0);
    repeat (4) @(posedge ref_clk);
    check(32'(op_mode), 32'h1);
    node.hold(1'b0);
    set_mode(3'h0);
    check(32'(op_mode), 32'h0);
    rd_chk(`OFS_ERROR_CNT, 32'h3);
    wr(`OFS_MODULE_CTRL, 32'h8);
    rd_chk(`OFS_ERROR_CNT, 32'h0);
    rd_chk(`OFS_MODULE_INFO, 32'h0);
    for (int m = 2; m < 6; m++) begin
      set_mode(3'(m));
      check(32'(op_mode), 32'(m));
      set_mode(3'h0);
      check(32'(op_mode), 32'h0);
    end
    // redefine a pending transmit buffer: abort, confirm, rewrite, wait, request
    wr(ba(12, 0), 32'h2);
    rd_chk(ba(12, 0), 32'h1);
    wr(ba(12, 0), 32'h1);
    wr(ba(12, 2), EXT | 32'h500);
    repeat (16) @(posedge ref_clk);
    wr(ba(12, 0), 32'h100);
    wr(ba(12, 0), 32'h200);
    rd_chk(ba(12, 2), EXT | 32'h500);
    rd_chk(`OFS_TX_RESULT, 32'h1d);
    wr(`OFS_MODULE_CTRL, 32'h6);
    rd_chk(`OFS_MODULE_CTRL, 32'h0);
    close_out();
  end
endmodule

// *** dv/can_node_model.sv ***
/*
  behavioural model of the other nodes on the can bus, seen through the
  protocol engine lines of the mode controller.
  assumes the controller samples these lines on rising edges of ref_clk.
*/
`timescale 1ns/1ps
module can_node_model (
  // clock
  input  wire logic        ref_clk,
  // engine side lines
  output logic             bus_busy,
  output logic             rx_frame_done,
  output logic      [28:0] rx_id,
  output logic             rx_ide,
  output logic             err_event
);
  initial begin
    bus_busy      = 1'b0;
    rx_frame_done = 1'b0;
    rx_id         = 29'h0;
    rx_ide        = 1'b0;
    err_event     = 1'b0;
  end
  // busy spans the whole frame, so a pending init request has to wait
  task automatic frame(input logic [28:0] id, input logic ide);
    @(posedge ref_clk);
    bus_busy <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rx_id         <= id;
    rx_ide        <= ide;
    rx_frame_done <= 1'b1;
    @(posedge ref_clk);
    rx_frame_done <= 1'b0;
    // id lines are not held after the store point; invert so a stale id cannot match
    rx_id         <= ~id;
    rx_ide        <= ~ide;
    repeat (3) @(posedge ref_clk);
    bus_busy <= 1'b0;
  endtask
  task automatic hold(input logic on);
    @(posedge ref_clk);
    bus_busy <= on;
  endtask
  task automatic errs(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      err_event <= 1'b1;
      @(posedge ref_clk);
      err_event <= 1'b0;
    end
  endtask
endmodule

// *** logic/can_ctrl_pkg.sv ***
/*
  types for the can mode and receive-search block.
  assumes can_ctrl_regs.svh supplies the numbers.
*/
package can_ctrl_pkg;
  typedef enum logic [1:0] {
    ST_OFF  = 2'b00,
    ST_INIT = 2'b01,
    ST_OPER = 2'b10,
    ST_WAIT = 2'b11
  } mode_state_t;
  typedef struct packed {
    logic       in_use;
    logic       overwrite_enable;
    logic [2:0] btype;
    logic       ready;
    logic       tx_req;
    logic       data_new;
    logic [28:0] id;
    logic       ide;
    logic       rtr;
  } buf_view_t;
  typedef struct packed {
    logic       hit;
    logic       store;
    logic [3:0] num;
  } search_res_t;
endpackage

// *** logic/can_ctrl_regs.svh ***
/*
  register offsets, field positions, reset values and encodings for the can mode
  and receive-search block.
  assumes inclusion by bare name; definitions only.
*/
// Functional notes
// R1 - software sets the clock divider before enable and keeps it while enabled
// R2 - setting global operation enable starts the controller in initialization mode
// R3 - buffer contents are undefined right after enable
// R4 - software clears ready, request, data-new and in-use of buffers 0..15 first
// R5 - redefinition: enter init mode, rewrite buffer, select operation mode again
// R6 - abort a pending transmit and confirm before rewriting that buffer
// R7 - wait one bit time after redefining an aborted transmit buffer
// R8 - pick highest-priority pending transmit buffer by identifier, extension, remote bit
// R9 - three-bit mode field selects one of five modes out of init
// R10 - every change between operation modes passes through init mode
// R11 - init request pends during a frame; entered at interframe space, field reads 000
// R12 - software polls the mode field until it reads 000
// R13 - clear-error-counter in init mode resets error counter and module info
// R14 - receive search considers in-use, type 001..101, ready buffers only
// R15 - frame goes only to the highest priority class candidate
// R16 - if best candidate is full with overwrite off, frame is discarded
// R17 - classes: unmasked 1, mask1 2, mask2 3; accept if empty or overwrite
// R18 - mask3 class 4, mask4 class 5, same accept conditions
// R19 - while ready, software writes only reach ready, request, data-new, overwrite (here overwrite sits in the conf word and is locked too)
// R20 - within one class the lowest buffer number wins
`ifndef CAN_CTRL_REGS_SVH
`define CAN_CTRL_REGS_SVH
`define NUM_BUF          16
`define OFS_GLOBAL_CTRL  12'h000
`define OFS_CLOCK_SEL    12'h004
`define OFS_MODULE_CTRL  12'h008
`define OFS_ERROR_CNT    12'h00c
`define OFS_MODULE_INFO  12'h010
`define OFS_FRAME_STAT   12'h014
`define OFS_RX_RESULT    12'h018
`define OFS_TX_RESULT    12'h01c
`define OFS_BUF_BASE     12'h100
`define OFS_BUF_STRIDE   12'h010
`define BUF_CTRL_WORD    2'h0
`define BUF_CONF_WORD    2'h1
`define BUF_ID_WORD      2'h2
`define CTRL_READY       0
`define CTRL_TX_REQ      1
`define CTRL_DATA_NEW    2
`define CTRL_OVERWRITE   4
`define CONF_IN_USE      0
`define CONF_OVERWRITE   1
`define CONF_TYPE_LO     3
`define MC_MODE_LO       0
`define MC_CLR_ERR       3
`define GC_ENABLE        0
`define MODE_INIT        3'h0
`define TYPE_TX          3'h0
`define TYPE_RX_LO       3'h1
`define TYPE_RX_HI       3'h5
`define MODE_HI          3'h5
`define ERR_CNT_RESET    16'h0000
`define MOD_INFO_RESET   8'h00
`endif

// *** logic/can_mode_ctrl.sv ***
/*
  can controller mode control, message buffer store and receive placement,
  reached over apb.
  assumes protocol engine signals (frame activity, frame end, id) on ref_clk.
*/
`timescale 1ns/1ps
`include "can_ctrl_regs.svh"
module can_mode_ctrl
  import can_ctrl_pkg::*;
#(
  parameter int NB = `NUM_BUF
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // protocol engine side
  input  wire logic        bus_busy,
  input  wire logic        rx_frame_done,
  input  wire logic [28:0] rx_id,
  input  wire logic        rx_ide,
  input  wire logic        err_event,
  // status toward the engine
  output logic      [2:0]  op_mode,
  output logic             ctrl_enabled,
  output logic      [3:0]  clock_divider,
  output logic             tx_valid,
  output logic      [3:0]  tx_buf
);
  if (NB != `NUM_BUF) begin : g_bad_nb
    $error("can_mode_ctrl: NB must be NUM_BUF");
  end
  mode_state_t state, next_state;
  logic [2:0]  mode, next_mode, pend_mode, next_pend_mode;
  logic [3:0]  module_clock_divider, next_module_clock_divider;
  logic        global_operation_enable, next_global_operation_enable;
  logic [15:0] error_counter_reg, next_error_counter_reg;
  logic [7:0]  module_info_reg, next_module_info_reg;
  logic [4:0]  rx_result, next_rx_result;
  logic [1:0]  frame_stat, next_frame_stat;
  logic [31:0] next_prdata;
  logic        next_pready, next_pslverr;
  logic        next_tx_valid;
  logic [3:0]  next_tx_buf;
  buf_view_t   bufs [NB];
  buf_view_t   next_bufs [NB];
  logic [NB-1:0] id_match;
  search_res_t rx_res, tx_res;

  wire acc    = psel && penable && !pready;
  wire wr     = psel && penable && pready && pwrite; // lands where the master sees pready
  wire in_buf = paddr >= `OFS_BUF_BASE &&
                paddr < `OFS_BUF_BASE + 12'(NB) * `OFS_BUF_STRIDE;
  wire [11:0] boff  = paddr - `OFS_BUF_BASE;
  wire [3:0]  bidx  = boff[7:4];
  wire [1:0]  bword = boff[3:2];

  genvar g;
  generate
    for (g = 0; g < NB; g++) begin : g_match
      // standard frames compare only the upper eleven id bits
      assign id_match[g] = (bufs[g].ide == rx_ide) &&
        (rx_ide ? bufs[g].id == rx_id : bufs[g].id[28:18] == rx_id[28:18]);
    end
  endgenerate

  can_rx_search #(.NB(NB)) u_search (
    .bufs     (bufs),
    .id_match (id_match),
    .rx_res   (rx_res),
    .tx_res   (tx_res)
  );

  // mode and control registers
  always_comb begin
    next_state = state;
    next_mode = mode;
    next_pend_mode = pend_mode;
    next_module_clock_divider = module_clock_divider;
    next_global_operation_enable = global_operation_enable;
    next_error_counter_reg = error_counter_reg;
    next_module_info_reg = module_info_reg;
    if (err_event && error_counter_reg != 16'hffff) begin
      next_error_counter_reg = error_counter_reg + 16'h0001;
    end
    case (state)
      ST_OFF: begin
        if (global_operation_enable) begin
          next_state = ST_INIT; // [R2]
        end
      end
      ST_INIT: begin
        next_mode = `MODE_INIT;
        if (pend_mode != `MODE_INIT) begin
          next_mode = pend_mode; // [R9]
          next_state = ST_OPER;
        end
      end
      ST_OPER: begin
        if (pend_mode == `MODE_INIT) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!bus_busy) begin
          next_mode = `MODE_INIT; // [R11]
          next_state = ST_INIT;
        end
      end
      default: next_state = ST_OFF;
    endcase
    if (wr && paddr == `OFS_GLOBAL_CTRL) begin
      next_global_operation_enable = pwdata[`GC_ENABLE];
      if (!pwdata[`GC_ENABLE]) begin
        next_state = ST_OFF;
        next_mode = `MODE_INIT;
        next_pend_mode = `MODE_INIT;
      end
    end
    // divider frozen while enabled
    if (wr && paddr == `OFS_CLOCK_SEL && !global_operation_enable) begin
      next_module_clock_divider = pwdata[3:0];
    end
    if (wr && paddr == `OFS_MODULE_CTRL && state != ST_OFF) begin
      if (pwdata[`MC_MODE_LO +: 3] <= `MODE_HI) begin
        next_pend_mode = pwdata[`MC_MODE_LO +: 3];
      end
      if (pwdata[`MC_CLR_ERR] && state == ST_INIT) begin
        next_error_counter_reg = `ERR_CNT_RESET; // [R13]
        next_module_info_reg = `MOD_INFO_RESET; // [R13]
      end
    end
    next_module_info_reg[0] = (error_counter_reg[7:0] >= 8'h60);
    if (state == ST_OFF) begin
      next_module_info_reg[0] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_OFF;
      mode <= `MODE_INIT;
      pend_mode <= `MODE_INIT;
      module_clock_divider <= 4'h0;
      global_operation_enable <= 1'b0;
      error_counter_reg <= `ERR_CNT_RESET;
      module_info_reg <= `MOD_INFO_RESET;
    end else begin
      state <= next_state;
      mode <= next_mode;
      pend_mode <= next_pend_mode;
      module_clock_divider <= next_module_clock_divider;
      global_operation_enable <= next_global_operation_enable;
      error_counter_reg <= next_error_counter_reg;
      module_info_reg <= next_module_info_reg;
    end
  end

  // message buffers: software writes and receive placement
  always_comb begin
    for (int i = 0; i < NB; i++) begin
      next_bufs[i] = bufs[i];
    end
    next_rx_result = rx_result;
    next_frame_stat = frame_stat;
    if (wr && in_buf) begin
      case (bword)
        `BUF_CTRL_WORD: begin
          // set in bits 8 and 9, clear in bits 0 to 2; set and clear together is no change
          if (pwdata[8] && !pwdata[0]) next_bufs[bidx].ready = 1'b1;
          if (!pwdata[8] && pwdata[0]) next_bufs[bidx].ready = 1'b0;
          if (pwdata[9] && !pwdata[1]) next_bufs[bidx].tx_req = 1'b1;
          if (!pwdata[9] && pwdata[1]) next_bufs[bidx].tx_req = 1'b0;
          if (pwdata[2]) next_bufs[bidx].data_new = 1'b0;
        end
        `BUF_CONF_WORD: begin
          if (!bufs[bidx].ready) begin // [R19]
            next_bufs[bidx].in_use = pwdata[`CONF_IN_USE];
            next_bufs[bidx].overwrite_enable = pwdata[`CONF_OVERWRITE];
            next_bufs[bidx].btype = pwdata[`CONF_TYPE_LO +: 3];
          end
        end
        `BUF_ID_WORD: begin
          if (!bufs[bidx].ready) begin // [R19]
            next_bufs[bidx].id = pwdata[28:0];
            next_bufs[bidx].ide = pwdata[31];
            next_bufs[bidx].rtr = pwdata[30];
          end
        end
        default: ;
      endcase
    end
    // hardware store wins over a same-cycle software clear of data_new
    if (rx_frame_done && state == ST_OPER || rx_frame_done && state == ST_WAIT) begin
      next_rx_result = {rx_res.hit && rx_res.store, rx_res.num};
      next_frame_stat = {rx_res.hit, rx_res.hit && !rx_res.store};
      if (rx_res.hit && rx_res.store) begin
        next_bufs[rx_res.num].data_new = 1'b1; // [R15] [R16]
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NB; i++) begin
        bufs[i] <= '0; // for determinism only, software still initialises them [R3]
      end
      rx_result <= 5'h00;
      frame_stat <= 2'h0;
    end else begin
      for (int i = 0; i < NB; i++) begin
        bufs[i] <= next_bufs[i];
      end
      rx_result <= next_rx_result;
      frame_stat <= next_frame_stat;
    end
  end

  // apb read path, registered, one wait cycle per access
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    next_pready = acc;
    if (in_buf) begin
      case (bword)
        `BUF_CTRL_WORD: next_prdata = {29'h0, bufs[bidx].data_new,
                                       bufs[bidx].tx_req, bufs[bidx].ready};
        `BUF_CONF_WORD: next_prdata = {26'h0, bufs[bidx].btype, 1'b0,
                                       bufs[bidx].overwrite_enable, bufs[bidx].in_use};
        `BUF_ID_WORD:   next_prdata = {bufs[bidx].ide, bufs[bidx].rtr, 1'b0,
                                       bufs[bidx].id};
        default:        next_pslverr = acc;
      endcase
    end else begin
      case (paddr)
        `OFS_GLOBAL_CTRL: next_prdata = {31'h0, global_operation_enable};
        `OFS_CLOCK_SEL:   next_prdata = {28'h0, module_clock_divider};
        `OFS_MODULE_CTRL: next_prdata = {29'h0, mode}; // [R11]
        `OFS_ERROR_CNT:   next_prdata = {16'h0, error_counter_reg};
        `OFS_MODULE_INFO: next_prdata = {24'h0, module_info_reg};
        `OFS_FRAME_STAT:  next_prdata = {30'h0, frame_stat};
        `OFS_RX_RESULT:   next_prdata = {27'h0, rx_result};
        `OFS_TX_RESULT:   next_prdata = {27'h0, tx_res.hit, tx_res.num};
        default:          next_pslverr = acc;
      endcase
    end
    next_tx_valid = tx_res.hit && state == ST_OPER;
    next_tx_buf = tx_res.num;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      op_mode <= `MODE_INIT;
      ctrl_enabled <= 1'b0;
      clock_divider <= 4'h0;
      tx_valid <= 1'b0;
      tx_buf <= 4'h0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      op_mode <= next_mode;
      ctrl_enabled <= next_state != ST_OFF;
      clock_divider <= next_module_clock_divider;
      tx_valid <= next_tx_valid;
      tx_buf <= next_tx_buf;
    end
  end

  AST_INIT_ON_ENABLE: assert property (@(posedge ref_clk) disable iff (!nrst)
    state == ST_OFF && global_operation_enable && !wr |=> state == ST_INIT) // [R2]
    else $error("enable did not enter init");
  AST_INIT_HELD_BUSY: assert property (@(posedge ref_clk) disable iff (!nrst)
    state == ST_WAIT && bus_busy && !wr |=> mode != `MODE_INIT) // [R11]
    else $error("init entered during frame");
  AST_INIT_AT_IFS: assert property (@(posedge ref_clk) disable iff (!nrst)
    state == ST_WAIT && !bus_busy && !wr |=> mode == `MODE_INIT) // [R11]
    else $error("init not entered at interframe");
  AST_CLR_ERR: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr && paddr == `OFS_MODULE_CTRL && pwdata[`MC_CLR_ERR] && state == ST_INIT
    |=> error_counter_reg == `ERR_CNT_RESET) // [R13]
    else $error("error counter not cleared");
  AST_MODE_SELECT: assert property (@(posedge ref_clk) disable iff (!nrst)
    state == ST_INIT && pend_mode != `MODE_INIT && !wr |=> mode == $past(pend_mode)) // [R9]
    else $error("mode not taken");
  AST_DISCARD: assert property (@(posedge ref_clk) disable iff (!nrst)
    rx_frame_done && state == ST_OPER && rx_res.hit && !rx_res.store
    |=> rx_result[4] == 1'b0 && frame_stat == 2'b11) // [R16]
    else $error("full best candidate not discarded");
  AST_STORE_DN: assert property (@(posedge ref_clk) disable iff (!nrst)
    rx_frame_done && state == ST_OPER && rx_res.hit && rx_res.store
    |=> bufs[rx_result[3:0]].data_new) // [R15]
    else $error("stored buffer lacks data_new");
  AST_ELIG: assert property (@(posedge ref_clk) disable iff (!nrst)
    rx_res.hit |-> bufs[rx_res.num].in_use && bufs[rx_res.num].ready &&
    bufs[rx_res.num].btype inside {[3'h1:3'h5]}) // [R14]
    else $error("ineligible receive target");
  AST_RDY_LOCK: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr && in_buf && bword == `BUF_ID_WORD && bufs[bidx].ready
    |=> bufs[$past(bidx)].id == $past(bufs[bidx].id)) // [R19]
    else $error("locked buffer id changed");
endmodule

// *** logic/can_rx_search.sv ***
/*
  combinational search over all buffers: receive target and best transmit buffer.
  assumes match vector from the id filter of the caller, same clock.
*/
`timescale 1ns/1ps
`include "can_ctrl_regs.svh"
module can_rx_search
  import can_ctrl_pkg::*;
#(
  parameter int NB = `NUM_BUF
) (
  // buffer state
  input  wire buf_view_t   bufs [NB],
  input  wire logic [NB-1:0] id_match,
  // results
  output search_res_t      rx_res,
  output search_res_t      tx_res
);
  if (NB < 1 || NB > 16) begin : g_bad_nb
    $error("can_rx_search: NB out of range");
  end
  logic [NB-1:0] elig;
  logic [2:0]    cls [NB];
  genvar g;
  generate
    for (g = 0; g < NB; g++) begin : g_elig
      // class is type code: 1 unmasked .. 5 mask 4
      assign elig[g] = bufs[g].in_use && bufs[g].ready && id_match[g] &&
                       bufs[g].btype >= `TYPE_RX_LO &&
                       bufs[g].btype <= `TYPE_RX_HI; // [R14]
      assign cls[g]  = bufs[g].btype; // [R17] [R18]
    end
  endgenerate
  always_comb begin
    logic [2:0] best_cls;
    logic [30:0] best_key;
    best_cls = 3'h7;
    best_key = 31'h7fffffff;
    rx_res = '0;
    tx_res = '0;
    // strict less keeps the lowest number in a class
    for (int i = 0; i < NB; i++) begin
      if (elig[i] && cls[i] < best_cls) begin // [R15] [R20]
        best_cls = cls[i];
        rx_res.hit = 1'b1;
        rx_res.num = 4'(i);
        rx_res.store = !bufs[i].data_new || bufs[i].overwrite_enable; // [R16] [R17]
      end
    end
    // lower key wins arbitration: id then extension then remote bit
    for (int i = 0; i < NB; i++) begin
      if (bufs[i].in_use && bufs[i].ready && bufs[i].tx_req &&
          bufs[i].btype == `TYPE_TX &&
          (!tx_res.hit || {bufs[i].id, bufs[i].ide, bufs[i].rtr} < best_key)) begin // [R8]
        best_key = {bufs[i].id, bufs[i].ide, bufs[i].rtr};
        tx_res.hit = 1'b1;
        tx_res.num = 4'(i);
      end
    end
  end
endmodule
